/* rtl/tsr_regs.sv */
// Register bank of a dual-axis tilt sensor: output words, sample timer, sleep, filter, lines and DAC.
// Assumes an SPI slave front end on clk_sys presenting byte reads and writes by 6-bit address.
`timescale 1ns/10ps
module tsr_regs #(
    parameter int unsigned SLEEP_UNIT_CYCLES = tsr_pkg::SLEEP_UNIT_CYC,
    parameter int unsigned BASE_FAST_CYCLES = tsr_pkg::BASE_FAST_CYC,
    parameter int unsigned BASE_SLOW_CYCLES = tsr_pkg::BASE_SLOW_CYC,
    parameter int unsigned PERIOD_ADD_CYCLES = tsr_pkg::PERIOD_ADD_CYC
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Byte register access from the serial front end.
    input wire logic [5:0] bus_addr,
    input wire logic bus_wr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    // Measurement values from the conversion path.
    input wire logic [13:0] meas_supply,
    input wire logic [13:0] meas_xaccel,
    input wire logic [13:0] meas_yaccel,
    input wire logic [11:0] meas_auxadc,
    input wire logic [11:0] meas_temp,
    input wire logic [13:0] meas_xtilt,
    input wire logic [13:0] meas_ytilt,
    input wire logic [13:0] meas_rot,
    input wire logic meas_fault,
    // Alarm engine claim on the lines.
    input wire logic alarm_enable,
    input wire logic alarm_line_sel,
    input wire logic alarm_level,
    // Self-test engine.
    output logic selftest_run,
    input wire logic selftest_done,
    input wire logic selftest_fail,
    // Status and filter controls.
    output logic status_selftest_err,
    output logic [3:0] filter_exponent,
    output logic sample_tick,
    output logic sleeping,
    // Multipurpose lines.
    input wire logic line_one_in,
    output logic line_one_out,
    output logic line_one_oe,
    input wire logic line_two_in,
    output logic line_two_out,
    output logic line_two_oe,
    // Auxiliary DAC output level.
    output logic [11:0] dac_level
);
    // Refuse cycle counts that would stall the timers.
    if (SLEEP_UNIT_CYCLES < 1 || BASE_FAST_CYCLES < 1 || BASE_SLOW_CYCLES < 1 || PERIOD_ADD_CYCLES < 1) begin
        $error("tsr_regs: cycle counts must be at least one");
    end

    typedef enum logic [1:0] {
        TSR_ST_IDLE = 2'b00,
        TSR_ST_START = 2'b01,
        TSR_ST_MANUAL = 2'b10
    } tsr_test_type;

    logic [15:0] period_reg;
    logic [15:0] avg_reg;
    logic [15:0] misc_reg;
    logic [15:0] gpio_reg;
    logic [15:0] dac_reg;
    logic [11:0] dac_out_reg;
    logic fresh_reg;
    logic err_reg;
    logic [7:0] sleep_left_reg;
    logic [31:0] sleep_tick_reg;
    logic [31:0] period_cnt_reg;
    logic [31:0] drdy_cnt_reg;
    logic [31:0] drdy_len_reg;
    logic drdy_reg;
    tsr_test_type test_reg;
    logic [1:0] one_sync_reg;
    logic [1:0] two_sync_reg;
    logic [7:0] rdata_reg;
    logic [15:0] rd_word;
    logic [31:0] period_len;
    logic in_test;
    logic tick;

    function automatic logic [15:0] out_word(input logic [13:0] data, input logic fresh, input logic fault);
        out_word = {fresh, fault, data};
    endfunction

    function automatic logic [15:0] set_byte(input logic [15:0] cur, input logic hi, input logic [7:0] val);
        set_byte = hi ? {val, cur[7:0]} : {cur[15:8], val};
    endfunction

    assign in_test = (test_reg != TSR_ST_IDLE);
    assign sleeping = (sleep_left_reg != 8'h00);

    // Sample period from time base and increment count.
    always_comb begin
        period_len = (period_reg[tsr_pkg::PERIOD_BASE_BIT] ? BASE_SLOW_CYCLES : BASE_FAST_CYCLES)
            * 32'(period_reg[tsr_pkg::PERIOD_COUNT_W-1:0]) + PERIOD_ADD_CYCLES;
    end
    assign tick = !sleeping && (period_cnt_reg + 32'h1 >= period_len);
    assign sample_tick = tick;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            period_cnt_reg <= 32'h0;
        end else if (sleeping || tick) begin
            period_cnt_reg <= 32'h0;
        end else begin
            period_cnt_reg <= period_cnt_reg + 32'h1;
        end
    end

    // Configuration writes; period and averaging are locked during self-test.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            period_reg <= tsr_pkg::PERIOD_RESET;
            avg_reg <= tsr_pkg::AVG_RESET;
        end else if (bus_wr && !in_test && !sleeping) begin
            if (bus_addr[5:1] == tsr_pkg::ADDR_PERIOD[5:1]) begin
                period_reg <= set_byte(period_reg, bus_addr[0], bus_wdata) & 16'h00ff;
            end
            if (bus_addr == tsr_pkg::ADDR_AVG) begin
                if (bus_wdata[3:0] <= tsr_pkg::AVG_MAX) begin
                    avg_reg <= {12'h000, bus_wdata[3:0]};
                end
            end
        end
    end
    assign filter_exponent = avg_reg[tsr_pkg::AVG_W-1:0];

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            misc_reg <= tsr_pkg::MISC_RESET;
            gpio_reg <= tsr_pkg::GPIO_RESET;
        end else if (bus_wr && !sleeping) begin
            if (bus_addr[5:1] == tsr_pkg::ADDR_MISC[5:1]) begin
                misc_reg <= set_byte(misc_reg, bus_addr[0], bus_wdata) & tsr_pkg::MISC_MASK;
            end
            if (bus_addr[5:1] == tsr_pkg::ADDR_GPIO[5:1]) begin
                gpio_reg <= set_byte(gpio_reg, bus_addr[0], bus_wdata) & 16'h0303;
            end
        end
    end

    // Sleep counter: only reset cuts it short.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sleep_left_reg <= 8'h00;
            sleep_tick_reg <= 32'h0;
        end else if (sleeping) begin
            if (sleep_tick_reg + 32'h1 >= SLEEP_UNIT_CYCLES) begin
                sleep_tick_reg <= 32'h0;
                sleep_left_reg <= sleep_left_reg - 8'h01;
            end else begin
                sleep_tick_reg <= sleep_tick_reg + 32'h1;
            end
        end else if (bus_wr && bus_addr == tsr_pkg::ADDR_SLEEP) begin
            sleep_left_reg <= bus_wdata;
            sleep_tick_reg <= 32'h0;
        end
    end

    // Self-test sequencing: startup once unless suppressed, manual repeats while bit 8 is set.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            test_reg <= TSR_ST_START;
            err_reg <= 1'b0;
        end else begin
            unique case (test_reg)
                TSR_ST_START: begin
                    if (misc_reg[tsr_pkg::MISC_NOSTART_BIT] || selftest_done) begin
                        test_reg <= TSR_ST_IDLE;
                    end
                end
                TSR_ST_MANUAL: begin
                    if (!misc_reg[tsr_pkg::MISC_TEST_BIT] && selftest_done) begin
                        test_reg <= TSR_ST_IDLE;
                    end
                end
                TSR_ST_IDLE: begin
                    if (misc_reg[tsr_pkg::MISC_TEST_BIT]) begin
                        test_reg <= TSR_ST_MANUAL;
                    end
                end
                default: test_reg <= TSR_ST_IDLE;
            endcase
            if (in_test && selftest_done && selftest_fail) begin
                err_reg <= 1'b1;
            end else if (bus_rd && bus_addr == tsr_pkg::ADDR_STATUS) begin
                err_reg <= 1'b0;
            end
        end
    end
    assign selftest_run = in_test && !(test_reg == TSR_ST_START && misc_reg[tsr_pkg::MISC_NOSTART_BIT]);
    assign status_selftest_err = err_reg;

    // Fresh flag: set wins over a read in the same cycle.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fresh_reg <= 1'b0;
        end else if (tick) begin
            fresh_reg <= 1'b1;
        end else if (bus_rd && bus_addr >= tsr_pkg::ADDR_SUPPLY && bus_addr <= (tsr_pkg::ADDR_ROT | 6'h01)) begin
            fresh_reg <= 1'b0;
        end
    end

    // Data-ready pulse, one per update, high for a quarter period.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            drdy_reg <= 1'b0;
            drdy_cnt_reg <= 32'h0;
            drdy_len_reg <= 32'h1;
        end else if (tick) begin
            drdy_reg <= 1'b1;
            drdy_len_reg <= (period_len >> 2) == 32'h0 ? 32'h1 : (period_len >> 2);
            drdy_cnt_reg <= 32'h0;
        end else if (drdy_reg) begin
            if (drdy_cnt_reg + 32'h1 >= drdy_len_reg) begin
                drdy_reg <= 1'b0;
            end
            drdy_cnt_reg <= drdy_cnt_reg + 32'h1;
        end
    end

    // Line input synchronisers.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            one_sync_reg <= 2'b00;
            two_sync_reg <= 2'b00;
        end else begin
            one_sync_reg <= {one_sync_reg[0], line_one_in};
            two_sync_reg <= {two_sync_reg[0], line_two_in};
        end
    end

    // Line ownership by priority.
    always_comb begin
        logic drdy_lvl;
        logic alm_lvl;
        drdy_lvl = (drdy_reg == misc_reg[tsr_pkg::MISC_POL_BIT]);
        alm_lvl = alarm_level;
        line_one_oe = gpio_reg[0];
        line_one_out = gpio_reg[tsr_pkg::GPIO_DATA_LSB];
        line_two_oe = gpio_reg[1];
        line_two_out = gpio_reg[tsr_pkg::GPIO_DATA_LSB + 1];
        if (alarm_enable && !alarm_line_sel) begin
            line_one_oe = 1'b1;
            line_one_out = alm_lvl;
        end
        if (alarm_enable && alarm_line_sel) begin
            line_two_oe = 1'b1;
            line_two_out = alm_lvl;
        end
        if (misc_reg[tsr_pkg::MISC_DRDY_EN_BIT] && !misc_reg[tsr_pkg::MISC_LINE_BIT]) begin
            line_one_oe = 1'b1;
            line_one_out = drdy_lvl;
        end
        if (misc_reg[tsr_pkg::MISC_DRDY_EN_BIT] && misc_reg[tsr_pkg::MISC_LINE_BIT]) begin
            line_two_oe = 1'b1;
            line_two_out = drdy_lvl;
        end
    end

    // DAC staging register and output latch.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dac_reg <= 16'h0000;
            dac_out_reg <= 12'h000;
        end else if (bus_wr && !sleeping) begin
            if (bus_addr[5:1] == tsr_pkg::ADDR_DAC[5:1]) begin
                dac_reg <= set_byte(dac_reg, bus_addr[0], bus_wdata) & 16'h0fff;
            end
            if (bus_addr == tsr_pkg::ADDR_COMMAND && bus_wdata[tsr_pkg::CMD_DAC_LATCH_BIT]) begin
                dac_out_reg <= dac_reg[tsr_pkg::DAC_W-1:0];
            end
        end
    end
    assign dac_level = dac_out_reg;

    // Word selected by the read address.
    always_comb begin
        case ({bus_addr[5:1], 1'b0})
            tsr_pkg::ADDR_SUPPLY: rd_word = out_word(meas_supply, fresh_reg, meas_fault);
            tsr_pkg::ADDR_XACCL: rd_word = out_word(meas_xaccel, fresh_reg, meas_fault);
            tsr_pkg::ADDR_YACCL: rd_word = out_word(meas_yaccel, fresh_reg, meas_fault);
            tsr_pkg::ADDR_AUXADC: rd_word = out_word({2'b00, meas_auxadc}, fresh_reg, meas_fault);
            tsr_pkg::ADDR_TEMP: rd_word = out_word({2'b00, meas_temp}, fresh_reg, meas_fault);
            tsr_pkg::ADDR_XTILT: rd_word = out_word(meas_xtilt, fresh_reg, meas_fault);
            tsr_pkg::ADDR_YTILT: rd_word = out_word(meas_ytilt, fresh_reg, meas_fault);
            tsr_pkg::ADDR_ROT: rd_word = out_word(meas_rot, fresh_reg, meas_fault);
            tsr_pkg::ADDR_DAC: rd_word = dac_reg;
            tsr_pkg::ADDR_GPIO: rd_word = {6'h00, two_sync_reg[1], one_sync_reg[1], 6'h00, gpio_reg[1:0]};
            tsr_pkg::ADDR_MISC: rd_word = misc_reg;
            tsr_pkg::ADDR_PERIOD: rd_word = period_reg;
            tsr_pkg::ADDR_AVG: rd_word = avg_reg;
            tsr_pkg::ADDR_STATUS: rd_word = {10'h000, err_reg, 5'h00};
            default: rd_word = 16'h0000;
        endcase
    end

    // Read data for the addressed byte.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 8'h00;
        end else if (bus_rd) begin
            rdata_reg <= bus_addr[0] ? rd_word[15:8] : rd_word[7:0];
        end
    end
    assign bus_rdata = rdata_reg;
endmodule

/* rtl/tsr_pkg.sv */
// Register map, field layouts, reset values and timing counts for the tilt sensor register bank.
// Assumes a 100 MHz system clock and byte-wide register access with 6-bit byte addresses.
package tsr_pkg;
    localparam int unsigned CLK_HZ = 100000000;
    // Byte addresses of the low byte of each register.
    localparam logic [5:0] ADDR_SUPPLY = 6'h02;
    localparam logic [5:0] ADDR_XACCL = 6'h04;
    localparam logic [5:0] ADDR_YACCL = 6'h06;
    localparam logic [5:0] ADDR_AUXADC = 6'h08;
    localparam logic [5:0] ADDR_TEMP = 6'h0a;
    localparam logic [5:0] ADDR_XTILT = 6'h0c;
    localparam logic [5:0] ADDR_YTILT = 6'h0e;
    localparam logic [5:0] ADDR_ROT = 6'h10;
    localparam logic [5:0] ADDR_DAC = 6'h30;
    localparam logic [5:0] ADDR_GPIO = 6'h32;
    localparam logic [5:0] ADDR_MISC = 6'h34;
    localparam logic [5:0] ADDR_PERIOD = 6'h36;
    localparam logic [5:0] ADDR_AVG = 6'h38;
    localparam logic [5:0] ADDR_SLEEP = 6'h3a;
    localparam logic [5:0] ADDR_STATUS = 6'h3c;
    localparam logic [5:0] ADDR_COMMAND = 6'h3e;
    // Reset values.
    localparam logic [15:0] PERIOD_RESET = 16'h0014;
    localparam logic [15:0] AVG_RESET = 16'h0008;
    localparam logic [15:0] MISC_RESET = 16'h0000;
    localparam logic [15:0] GPIO_RESET = 16'h0000;
    // Output word layout.
    localparam int FRESH_BIT = 15;
    localparam int FAULT_BIT = 14;
    localparam int DATA_W = 14;
    localparam int NARROW_W = 12;
    // Field positions.
    localparam int PERIOD_BASE_BIT = 7;
    localparam int PERIOD_COUNT_W = 7;
    localparam int AVG_W = 4;
    localparam logic [3:0] AVG_MAX = 4'h8;
    localparam int MISC_LINE_BIT = 0;
    localparam int MISC_POL_BIT = 1;
    localparam int MISC_DRDY_EN_BIT = 2;
    localparam int MISC_TEST_BIT = 8;
    localparam int MISC_NOSTART_BIT = 10;
    localparam logic [15:0] MISC_MASK = 16'h0507;
    localparam logic [15:0] GPIO_DIR_MASK = 16'h0003;
    localparam int GPIO_DATA_LSB = 8;
    localparam int CMD_DAC_LATCH_BIT = 2;
    localparam int STATUS_SELFTEST_BIT = 5;
    localparam int DAC_W = 12;
    // Timing in nanoseconds (sleep unit in milliseconds) and derived cycle counts.
    localparam int unsigned BASE_FAST_NS = 244140;
    localparam int unsigned BASE_SLOW_NS = 7568000;
    localparam int unsigned PERIOD_ADD_NS = 122070;
    localparam int unsigned SLEEP_UNIT_MS = 500;
    localparam int unsigned BASE_FAST_CYC = BASE_FAST_NS / (1000000000 / CLK_HZ);
    localparam int unsigned BASE_SLOW_CYC = BASE_SLOW_NS / (1000000000 / CLK_HZ);
    localparam int unsigned PERIOD_ADD_CYC = PERIOD_ADD_NS / (1000000000 / CLK_HZ);
    localparam int unsigned SLEEP_UNIT_CYC = SLEEP_UNIT_MS * (CLK_HZ / 1000);
endpackage

/* sim/tsr_regs_props.sv */
// Concurrent checks on the ports of the tilt sensor register bank.
// Assumes one clock domain and the bind statement at the foot of this file.
`timescale 1ns/10ps
module tsr_regs_props (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Register access.
    input wire logic [5:0] bus_addr,
    input wire logic bus_wr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_rd,
    input wire logic [7:0] bus_rdata,
    // Engines and outputs.
    input wire logic alarm_enable,
    input wire logic alarm_line_sel,
    input wire logic selftest_run,
    input wire logic selftest_done,
    input wire logic selftest_fail,
    input wire logic status_selftest_err,
    input wire logic [3:0] filter_exponent,
    input wire logic sample_tick,
    input wire logic sleeping,
    input wire logic line_one_oe,
    input wire logic line_two_oe,
    input wire logic [11:0] dac_level
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    chk_tick_gap: assert property (sample_tick |=> !sample_tick [*2])
        else $error("sample ticks closer than the period offset");
    chk_sleep_len: assert property ($rose(sleeping) |-> sleeping [*8])
        else $error("sleep ended too early");
    chk_dac_hold: assert property (!(bus_wr && bus_addr == tsr_pkg::ADDR_COMMAND && bus_wdata[tsr_pkg::CMD_DAC_LATCH_BIT])
        |=> $stable(dac_level))
        else $error("dac level moved without a latch command");
    chk_filter_max: assert property (filter_exponent <= 4'h8)
        else $error("filter exponent above the highest legal setting");
    chk_rdata_hold: assert property (!bus_rd |=> $stable(bus_rdata))
        else $error("read byte changed without a read");
    chk_err_set: assert property (selftest_run && selftest_done && selftest_fail |=> status_selftest_err)
        else $error("self-test failure did not set the error flag");
    chk_alarm_one: assert property (alarm_enable && !alarm_line_sel |-> line_one_oe)
        else $error("alarm claim on line one not driven");
    chk_alarm_two: assert property (alarm_enable && alarm_line_sel |-> line_two_oe)
        else $error("alarm claim on line two not driven");
    cov_sleep: cover property ($rose(sleeping));
endmodule

bind tsr_regs tsr_regs_props u_tsr_regs_props (.clk_sys(clk_sys), .resetn(resetn), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .alarm_enable(alarm_enable),
    .alarm_line_sel(alarm_line_sel), .selftest_run(selftest_run), .selftest_fail(selftest_fail),
    .selftest_done(selftest_done),
    .status_selftest_err(status_selftest_err), .filter_exponent(filter_exponent), .sample_tick(sample_tick),
    .sleeping(sleeping), .line_one_oe(line_one_oe), .line_two_oe(line_two_oe), .dac_level(dac_level));

/* sim/tsr_host_model.sv */
// Host side model issuing single byte reads and writes to the register bank.
// Assumes the register bank samples strobes on the rising edge of clk_sys.
`timescale 1ns/10ps
module tsr_host_model (
    // Clock.
    input wire logic clk_sys,
    // Byte access.
    output logic [5:0] bus_addr,
    output logic bus_wr,
    output logic [7:0] bus_wdata,
    output logic bus_rd,
    input wire logic [7:0] bus_rdata
);
    initial begin
        bus_addr = 6'h00;
        bus_wr = 1'b0;
        bus_wdata = 8'h00;
        bus_rd = 1'b0;
    end
    // One byte per strobe, never faster than one strobe every two cycles.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
        bus_wdata <= ~d;
        bus_addr <= ~a;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        bus_addr <= ~a;
        #1;
        d = bus_rdata;
    endtask
endmodule

/* sim/tilt_sensor_output_and_control_regs_tb.sv */
// Self-checking bench for the tilt sensor register bank with shortened timing counts.
// Assumes the host model drives the byte bus and the bench drives every other input.
`timescale 1ns/10ps
module tilt_sensor_output_and_control_regs_tb;
    localparam int unsigned SLP = 10;
    localparam int unsigned BF = 2;
    localparam int unsigned BS = 5;
    localparam int unsigned ADD = 3;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [5:0] bus_addr;
    logic bus_wr, bus_rd;
    logic [7:0] bus_wdata, bus_rdata;
    logic [13:0] meas [8] = '{default: 14'h0000};
    logic meas_fault = 1'b0, alarm_enable = 1'b0, alarm_line_sel = 1'b0, alarm_level = 1'b0;
    logic selftest_done = 1'b0, selftest_fail = 1'b0, pin_one = 1'b0, pin_two = 1'b0;
    logic selftest_run, status_selftest_err, sample_tick, sleeping;
    logic line_one_out, line_one_oe, line_two_out, line_two_oe;
    logic [3:0] filter_exponent;
    logic [11:0] dac_level;
    wire logic line_one = line_one_oe ? line_one_out : pin_one;
    wire logic line_two = line_two_oe ? line_two_out : pin_two;
    int errors = 0;
    int compares = 0;
    int sleep_duration_reg = 0;
    tsr_host_model u_tsr_host_model (.clk_sys(clk_sys), .bus_addr(bus_addr), .bus_wr(bus_wr),
        .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
    tsr_regs #(.SLEEP_UNIT_CYCLES(SLP), .BASE_FAST_CYCLES(BF), .BASE_SLOW_CYCLES(BS), .PERIOD_ADD_CYCLES(ADD))
    u_tsr_regs (.clk_sys(clk_sys), .resetn(resetn), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .meas_supply(meas[0]), .meas_xaccel(meas[1]),
        .meas_yaccel(meas[2]), .meas_auxadc(meas[3][11:0]), .meas_temp(meas[4][11:0]), .meas_xtilt(meas[5]),
        .meas_ytilt(meas[6]), .meas_rot(meas[7]), .meas_fault(meas_fault), .alarm_enable(alarm_enable),
        .alarm_line_sel(alarm_line_sel), .alarm_level(alarm_level), .selftest_run(selftest_run),
        .selftest_done(selftest_done), .selftest_fail(selftest_fail), .status_selftest_err(status_selftest_err),
        .filter_exponent(filter_exponent), .sample_tick(sample_tick), .sleeping(sleeping),
        .line_one_in(line_one), .line_one_out(line_one_out), .line_one_oe(line_one_oe), .line_two_in(line_two),
        .line_two_out(line_two_out), .line_two_oe(line_two_oe), .dac_level(dac_level));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (sleeping === 1'b1) sleep_duration_reg <= sleep_duration_reg + 1;
    end
    task automatic end_of_test();
        if (errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task automatic rd16(input logic [5:0] a, output logic [15:0] v);
        u_tsr_host_model.rd(6'(a + 6'h01), v[15:8]);
        u_tsr_host_model.rd(a, v[7:0]);
    endtask
    task automatic wait_tick(output int n);
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (sample_tick !== 1'b1 && n < 300);
        if (n >= 300) begin
            errors++;
            end_of_test();
        end
    endtask
    task automatic pulse_done();
        @(posedge clk_sys);
        selftest_done <= 1'b1;
        @(posedge clk_sys);
        selftest_done <= 1'b0;
        cyc(2);
    endtask
    function automatic int per_model(input logic [7:0] v);
        return (v[7] ? BS : BF) * v[6:0] + ADD;
    endfunction
    logic [15:0] v;
    logic [7:0] pv [4] = '{8'h00, 8'h01, 8'h82, 8'h14};
    int n;
    initial begin
        void'($urandom(32'hf60ac3d9));
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        cyc(2);
        check("startup self-test", selftest_run, 16'h0001);
        pulse_done();
        rd16(tsr_pkg::ADDR_PERIOD, v);
        check("period reset", v, tsr_pkg::PERIOD_RESET);
        rd16(tsr_pkg::ADDR_AVG, v);
        check("avg reset", v, tsr_pkg::AVG_RESET);
        for (int i = 0; i < 8; i++) begin
            meas[i] <= (i == 3 || i == 4) ? 14'($urandom & 32'hfff) : 14'($urandom);
            meas_fault <= 1'($urandom);
            wait_tick(n);
            wait_tick(n);
            rd16(6'(tsr_pkg::ADDR_SUPPLY + 2 * i), v);
            check("output word", v, {1'b1, meas_fault, meas[i]});
            u_tsr_host_model.rd(6'(tsr_pkg::ADDR_SUPPLY + 2 * i + 1), v[7:0]);
            check("fresh after read", {8'h00, v[7]}, 16'h0000);
        end
        foreach (pv[i]) begin
            u_tsr_host_model.wr(tsr_pkg::ADDR_PERIOD, pv[i]);
            wait_tick(n);
            wait_tick(n);
            wait_tick(n);
            check("sample period", 16'(n), 16'(per_model(pv[i])));
        end
        u_tsr_host_model.wr(tsr_pkg::ADDR_AVG, 8'h03);
        u_tsr_host_model.wr(tsr_pkg::ADDR_AVG, 8'h09);
        cyc(2);
        check("avg over max", filter_exponent, 16'h0003);
        u_tsr_host_model.wr(tsr_pkg::ADDR_AVG, 8'h08);
        u_tsr_host_model.wr(6'(tsr_pkg::ADDR_MISC + 6'h01), 8'h01);
        cyc(2);
        check("manual self-test", selftest_run, 16'h0001);
        u_tsr_host_model.wr(tsr_pkg::ADDR_PERIOD, 8'h01);
        u_tsr_host_model.wr(tsr_pkg::ADDR_AVG, 8'h02);
        selftest_fail <= 1'b1;
        pulse_done();
        selftest_fail <= 1'b0;
        check("still testing", selftest_run, 16'h0001);
        rd16(tsr_pkg::ADDR_PERIOD, v);
        check("period locked", v, 16'h0014);
        rd16(tsr_pkg::ADDR_AVG, v);
        check("avg locked", v, 16'h0008);
        u_tsr_host_model.rd(tsr_pkg::ADDR_STATUS, v[7:0]);
        check("self-test error", v[tsr_pkg::STATUS_SELFTEST_BIT], 16'h0001);
        u_tsr_host_model.wr(6'(tsr_pkg::ADDR_MISC + 6'h01), 8'h00);
        pulse_done();
        check("test stopped", selftest_run, 16'h0000);
        u_tsr_host_model.wr(tsr_pkg::ADDR_MISC, 8'h05);
        wait_tick(n);
        n = 0;
        repeat (per_model(8'h14)) begin
            cyc(1);
            if (line_two_out === 1'b0 && line_two_oe === 1'b1) n++;
        end
        check("ready duty", 16'(n), 16'(per_model(8'h14) / 4));
        alarm_enable <= 1'b1;
        alarm_level <= 1'b1;
        u_tsr_host_model.wr(tsr_pkg::ADDR_GPIO, 8'h03);
        cyc(1);
        check("alarm over gpio", {line_one_oe, line_one_out}, 16'h0003);
        alarm_line_sel <= 1'b1;
        wait_tick(n);
        cyc(1);
        check("ready over alarm", {line_two_oe, line_two_out}, 16'h0002);
        alarm_enable <= 1'b0;
        cyc(2);
        check("gpio drives", {line_one_oe, line_one_out}, 16'h0002);
        u_tsr_host_model.wr(tsr_pkg::ADDR_MISC, 8'h00);
        u_tsr_host_model.wr(tsr_pkg::ADDR_GPIO, 8'h00);
        pin_one <= 1'($urandom);
        pin_two <= 1'($urandom);
        cyc(4);
        check("gpio inputs", {line_two_oe, line_one_oe}, 16'h0000);
        u_tsr_host_model.rd(6'(tsr_pkg::ADDR_GPIO + 6'h01), v[7:0]);
        check("line levels", v[7:0], {6'h00, pin_two, pin_one});
        u_tsr_host_model.wr(tsr_pkg::ADDR_DAC, 8'hab);
        u_tsr_host_model.wr(6'(tsr_pkg::ADDR_DAC + 6'h01), 8'h0c);
        cyc(2);
        check("dac before latch", dac_level, 16'h0000);
        u_tsr_host_model.wr(tsr_pkg::ADDR_COMMAND, 8'h04);
        cyc(2);
        check("dac latched", dac_level, 16'h0cab);
        u_tsr_host_model.wr(tsr_pkg::ADDR_SLEEP, 8'h03);
        u_tsr_host_model.wr(tsr_pkg::ADDR_MISC, 8'h04);
        #1;
        check("sleep kept", sleeping, 16'h0001);
        for (n = 0; sleeping === 1'b1 && n < 300; n++) cyc(1);
        if (n >= 300) begin
            errors++;
            end_of_test();
        end
        check("sleep length", 16'(sleep_duration_reg), 16'(3 * SLP));
        rd16(tsr_pkg::ADDR_MISC, v);
        check("write in sleep", v, 16'h0000);
        u_tsr_host_model.wr(tsr_pkg::ADDR_SLEEP, 8'h03);
        cyc(2);
        resetn <= 1'b0;
        cyc(1);
        check("reset ends sleep", {sleeping, dac_level}, 16'h0000);
        resetn <= 1'b1;
        cyc(2);
        u_tsr_host_model.wr(6'(tsr_pkg::ADDR_MISC + 6'h01), 8'h04);
        cyc(1);
        check("startup skipped", selftest_run, 16'h0000);
        rd16(tsr_pkg::ADDR_PERIOD, v);
        check("period after reset", v, tsr_pkg::PERIOD_RESET);
        end_of_test();
    end
endmodule
